/* mirror_defs.svh */
// Register map, field positions and reset values of the mirror selector
// Summary of operation
// RL1: Bit 15 global enable; zero disables all mirroring
// RL2: When enabled, copy selected frames to capture port
// RL3: Bit 14 set: only mirror copies reach capture
// RL4: Bits 4:0 name the single capture port
// RL5: 17-bit ingress mask picks mirrored receive ports
// RL6: Ingress mask bit i is switch port i
// RL7: Bit 29 enables mirroring every nth frame
// RL8: Divider bits 9:0 hold ratio n
// RL9: Divider applies only to mask-accepted frames
// RL10: Software keeps mirrored bandwidth within capture capacity
// RL11: Separate 17-bit egress mask mirrors transmitted frames
// RL12: Divider 0 or 1 mirrors all; rewrite restarts
// RL13: Read-only reserved bits read zero; RW kept
`ifndef MIRROR_DEFS_SVH
`define MIRROR_DEFS_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define IDX_CAP_CTRL 8'h10
`define IDX_IN_CTRL 8'h12
`define IDX_IN_DIV 8'h16
`define IDX_EG_CTRL 8'h1C
`define ADDR_W 10

// ****************************************************************
// Field positions
// ****************************************************************
`define CAP_EN_BIT 15
`define CAP_ONLY_BIT 14
`define CAP_PORT_MSB 4
`define MASK_MSB 16
`define DIV_EN_BIT 29
`define DIV_MSB 9
`define PORT_W 5
`define PORT_LAST 5'h10

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define REG_RESET 32'h0000_0000
`define CAP_WMASK 32'h0000_C01F
`define DIV_WMASK 32'h0000_03FF
`define FULL_WMASK 32'hFFFF_FFFF
`define DIV_ONE 10'h001
`define CNT_ZERO 10'h000

`endif

/* mirror_pkg.sv */
// Types shared by the mirror selector files
package mirror_pkg;
   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } resp_t;
endpackage : mirror_pkg

/* port_mask_match.sv */
// Checks a frame's port number against a 17-bit port mask
`timescale 1ns/1ps
`default_nettype none
`include "mirror_defs.svh"
module port_mask_match (
   input wire logic [`MASK_MSB:0] mask,
   input wire logic [`PORT_W-1:0] port,
   input wire logic frame,
   output logic hit
);
   // Bit i selects port i; ports past the last never match
   always_comb
   begin
      hit = frame && (port <= `PORT_LAST) && mask[port]; // RL6
   end
endmodule : port_mask_match
`default_nettype wire

/* frame_thinner.sv */
// Picks one in n eligible received frames
`timescale 1ns/1ps
`default_nettype none
`include "mirror_defs.svh"
module frame_thinner (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic thin_en,
   input wire logic [`DIV_MSB:0] div,
   input wire logic frame,
   output logic pick,
   output logic [`DIV_MSB:0] cnt
);
   logic bypass;
   logic last;
   logic [`DIV_MSB:0] cnt_r;

   // A ratio of 0 or 1 thins nothing, so every frame passes
   always_comb
   begin
      bypass = !thin_en || (div <= `DIV_ONE); // RL9 RL12
      last = (cnt_r == div - `DIV_ONE);
      pick = frame && (bypass || last); // RL7 RL8
      cnt = cnt_r;
   end

   // One shared count; a new ratio starts the count afresh
   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart || bypass) // RL12
         cnt_r <= `CNT_ZERO;
      else if (frame)
         cnt_r <= last ? `CNT_ZERO : cnt_r + `DIV_ONE; // RL8
   end
endmodule : frame_thinner
`default_nettype wire

/* port_mirror_selector.sv */
// Port mirror control registers and per-frame mirror decision
`timescale 1ns/1ps
`default_nettype none
`include "mirror_defs.svh"
module port_mirror_selector (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_frame,
   input wire logic [`PORT_W-1:0] rx_port,
   input wire logic tx_frame,
   input wire logic [`PORT_W-1:0] tx_port,
   output logic mirror_rx,
   output logic mirror_tx,
   output logic [`PORT_W-1:0] capture_port_select,
   output logic capture_only_copies
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] cap_ctrl_r;
   logic [31:0] in_ctrl_r;
   logic [31:0] in_div_r;
   logic [31:0] eg_ctrl_r;
   logic [`ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_full_r;
   logic w_full_r;
   logic aw_full_nxt;
   logic w_full_nxt;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic awready_r;
   logic wready_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic mirror_rx_r;
   logic mirror_tx_r;
   logic [`PORT_W-1:0] capture_port_r;
   logic capture_only_r;
   logic do_write;
   logic wr_hit;
   logic div_write;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic [31:0] rd_val;
   logic rd_hit;
   logic mirror_on;
   logic rx_hit;
   logic tx_hit;
   logic rx_pick;
   logic [`DIV_MSB:0] thin_cnt;

   // Merge written bytes into the old value, keeping fixed bits at zero
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb,
      input logic [31:0] wmask);
      logic [31:0] be;
      be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = ((old & ~be) | (data & be)) & wmask; // RL13
   endfunction : merge

   // ****************************************************************
   // Write address and write data capture, either order
   // ****************************************************************
   always_comb
   begin
      do_write = aw_full_r && w_full_r && !bvalid_r;
      aw_full_nxt = (aw_full_r && !do_write) ||
         (s_axi_awvalid && awready_r);
      w_full_nxt = (w_full_r && !do_write) ||
         (s_axi_wvalid && wready_r);
      wr_idx = awaddr_r[`ADDR_W-1:2];
      wr_hit = (wr_idx == `IDX_CAP_CTRL) || (wr_idx == `IDX_IN_CTRL) ||
         (wr_idx == `IDX_IN_DIV) || (wr_idx == `IDX_EG_CTRL);
      div_write = do_write && (wr_idx == `IDX_IN_DIV) && |wstrb_r;
   end

   // Each channel holds one item until the write completes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= `REG_RESET;
         wstrb_r <= 4'h0;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awready_r <= !aw_full_nxt;
         wready_r <= !w_full_nxt;
         if (s_axi_awvalid && awready_r)
            awaddr_r <= s_axi_awaddr;
         if (s_axi_wvalid && wready_r)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Write response; unmapped addresses get a slave error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= mirror_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? mirror_pkg::RESP_OKAY : mirror_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap_ctrl_r <= `REG_RESET; // RL1 RL4
         in_ctrl_r <= `REG_RESET; // RL5
         in_div_r <= `REG_RESET; // RL8
         eg_ctrl_r <= `REG_RESET; // RL11
      end
      else if (do_write)
      begin
         case (wr_idx)
            `IDX_CAP_CTRL:
               cap_ctrl_r <= merge(cap_ctrl_r, wdata_r, wstrb_r, `CAP_WMASK);
            `IDX_IN_CTRL:
               in_ctrl_r <= merge(in_ctrl_r, wdata_r, wstrb_r, `FULL_WMASK);
            `IDX_IN_DIV:
               in_div_r <= merge(in_div_r, wdata_r, wstrb_r, `DIV_WMASK);
            `IDX_EG_CTRL:
               eg_ctrl_r <= merge(eg_ctrl_r, wdata_r, wstrb_r, `FULL_WMASK);
            default:
               cap_ctrl_r <= cap_ctrl_r;
         endcase
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   always_comb
   begin
      rd_idx = s_axi_araddr[`ADDR_W-1:2];
      rd_hit = 1'b1;
      case (rd_idx)
         `IDX_CAP_CTRL: rd_val = cap_ctrl_r; // RL13
         `IDX_IN_CTRL: rd_val = in_ctrl_r;
         `IDX_IN_DIV: rd_val = in_div_r;
         `IDX_EG_CTRL: rd_val = eg_ctrl_r;
         default:
         begin
            rd_val = `REG_RESET;
            rd_hit = 1'b0;
         end
      endcase
   end

   // One read in flight; address refused while data waits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= `REG_RESET;
         rresp_r <= mirror_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_hit ? mirror_pkg::RESP_OKAY : mirror_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
      else
         arready_r <= !rvalid_r;
   end

   // ****************************************************************
   // Mirror decision
   // ****************************************************************
   // Global enable gates both directions and the blocking option
   assign mirror_on = cap_ctrl_r[`CAP_EN_BIT]; // RL1

   port_mask_match rx_match (.mask(in_ctrl_r[`MASK_MSB:0]), .port(rx_port),
      .frame(rx_frame && mirror_on), .hit(rx_hit));

   port_mask_match tx_match (.mask(eg_ctrl_r[`MASK_MSB:0]), .port(tx_port),
      .frame(tx_frame && mirror_on), .hit(tx_hit));

   // Thinning sees only frames the ingress mask already accepted
   frame_thinner thinner (.aclk(aclk), .aresetn(aresetn), .restart(div_write),
      .thin_en(in_ctrl_r[`DIV_EN_BIT]), .div(in_div_r[`DIV_MSB:0]),
      .frame(rx_hit), .pick(rx_pick), .cnt(thin_cnt));

   // Registered copy strobes, one cycle behind the frame strobes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mirror_rx_r <= 1'b0;
         mirror_tx_r <= 1'b0;
      end
      else
      begin
         mirror_rx_r <= rx_pick; // RL2 RL9
         mirror_tx_r <= tx_hit; // RL2 RL11
      end
   end

   // Capture port and blocking follow the control register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_port_r <= '0;
         capture_only_r <= 1'b0;
      end
      else
      begin
         capture_port_r <= cap_ctrl_r[`CAP_PORT_MSB:0]; // RL4
         capture_only_r <= mirror_on && cap_ctrl_r[`CAP_ONLY_BIT]; // RL3
      end
   end

   // ****************************************************************
   // Output drive
   // ****************************************************************
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign mirror_rx = mirror_rx_r;
   assign mirror_tx = mirror_tx_r;
   assign capture_port_select = capture_port_r;
   assign capture_only_copies = capture_only_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   mirror_off_a: assert property ( // RL1
      !cap_ctrl_r[`CAP_EN_BIT] |=> !mirror_rx && !mirror_tx)
      else $error("copy sent while mirroring disabled");
   rx_copy_a: assert property ( // RL2
      mirror_on && rx_frame && rx_port <= `PORT_LAST &&
      in_ctrl_r[rx_port] && !in_ctrl_r[`DIV_EN_BIT] |=> mirror_rx)
      else $error("accepted receive frame not mirrored");
   rx_mask_a: assert property ( // RL5
      rx_frame && (rx_port > `PORT_LAST || !in_ctrl_r[rx_port])
      |=> !mirror_rx)
      else $error("masked receive frame mirrored");
   tx_mask_a: assert property ( // RL11
      mirror_tx == $past(mirror_on && tx_frame && tx_port <= `PORT_LAST
      && eg_ctrl_r[tx_port]))
      else $error("egress copy does not follow mask");
   capture_only_a: assert property ( // RL3
      capture_only_copies == $past(cap_ctrl_r[`CAP_EN_BIT] &&
      cap_ctrl_r[`CAP_ONLY_BIT]))
      else $error("capture blocking wrong");
   capture_port_a: assert property ( // RL4
      $changed(cap_ctrl_r[`CAP_PORT_MSB:0]) |=>
      capture_port_select == $past(cap_ctrl_r[`CAP_PORT_MSB:0]))
      else $error("capture port not updated");
   thin_pick_a: assert property ( // RL7
      rx_hit && in_ctrl_r[`DIV_EN_BIT] && in_div_r[`DIV_MSB:0] > `DIV_ONE
      |-> rx_pick == (thin_cnt == in_div_r[`DIV_MSB:0] - `DIV_ONE))
      else $error("thinning picked wrong frame");
   thin_count_a: assert property ( // RL8
      rx_hit && !rx_pick && !div_write |=>
      thin_cnt == $past(thin_cnt) + `DIV_ONE)
      else $error("eligible frame not counted");
   thin_restart_a: assert property ( // RL12
      div_write |=> thin_cnt == `CNT_ZERO)
      else $error("divider write did not restart count");
   reserved_zero_a: assert property ( // RL13
      cap_ctrl_r[13:5] == 9'h000 && in_div_r[31:10] == 22'h00_0000)
      else $error("read-only reserved bits not zero");
   write_resp_a: assert property (
      do_write |=> s_axi_bvalid)
      else $error("write response missing");
   rx_seen_c: cover property (mirror_rx);
   tx_seen_c: cover property (mirror_tx);
   thin_skip_c: cover property (rx_hit && !rx_pick);
   bus_err_c: cover property (s_axi_bvalid && s_axi_bresp != 2'b00);
endmodule : port_mirror_selector
`default_nettype wire

/* fabric_model.sv */
// Behavioural model of the forwarding fabric beside the mirror selector
`timescale 1ns/1ps
`default_nettype none
`include "mirror_defs.svh"
module fabric_model (
   input wire logic aclk,
   output logic rx_frame,
   output logic [`PORT_W-1:0] rx_port,
   output logic tx_frame,
   output logic [`PORT_W-1:0] tx_port,
   input wire logic mirror_rx,
   input wire logic mirror_tx
);
   // ****************************************************************
   // Frame source and copy counters
   // ****************************************************************
   int rx_hits = 0;
   int tx_hits = 0;

   // Idle lines at time zero
   initial
   begin
      rx_frame = 1'b0;
      tx_frame = 1'b0;
      rx_port = '0;
      tx_port = '0;
   end

   // Back-to-back frames; at most one per cycle per direction
   // Ports show the inverse after a burst so stale values never match
   task automatic burst(input logic rx_on, input logic tx_on,
                        input logic [`PORT_W-1:0] p, input int n);
      @(posedge aclk);
      rx_frame <= rx_on;
      tx_frame <= tx_on;
      rx_port <= p;
      tx_port <= p;
      repeat (n) @(posedge aclk);
      rx_frame <= 1'b0;
      tx_frame <= 1'b0;
      rx_port <= ~p;
      tx_port <= ~p;
   endtask : burst

   // Count every copy pulse the selector hands back
   always @(posedge aclk)
   begin
      if (mirror_rx === 1'b1)
         rx_hits++;
      if (mirror_tx === 1'b1)
         tx_hits++;
   end
endmodule : fabric_model
`default_nettype wire

/* tb_port_mirror_selector.sv */
// Self-checking bench for the port mirror selector
`timescale 1ns/1ps
`default_nettype none
`include "mirror_defs.svh"
`define CHK(nm, got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("BAD %s exp %0h got %0h", nm, exp, got); \
      end \
   end
module tb_port_mirror_selector;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam logic [9:0] A_CAP = {`IDX_CAP_CTRL, 2'b00};
   localparam logic [9:0] A_ING = {`IDX_IN_CTRL, 2'b00};
   localparam logic [9:0] A_DIV = {`IDX_IN_DIV, 2'b00};
   localparam logic [9:0] A_EGR = {`IDX_EG_CTRL, 2'b00};
   localparam logic [1:0] OK = mirror_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = mirror_pkg::RESP_SLVERR;
   localparam logic [16:0] IN_M = 17'h1_2C35;
   localparam logic [16:0] EG_M = 17'h0_B4C9;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_frame, tx_frame;
   logic mirror_rx, mirror_tx, capture_only_copies;
   logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [`PORT_W-1:0] rx_port, tx_port, capture_port_select;
   logic [9:0] addr [4] = '{A_CAP, A_ING, A_DIV, A_EGR};
   logic [31:0] wmask [4] = '{32'h0000_C01F, 32'hFFFF_FFFF,
                              32'h0000_03FF, 32'hFFFF_FFFF};
   int error_cnt = 0;
   int samples_checked = 0;
   int rx_base = 0;
   int tx_base = 0;

   port_mirror_selector u_port_mirror_selector (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_frame, .rx_port,
      .tx_frame, .tx_port, .mirror_rx, .mirror_tx, .capture_port_select,
      .capture_only_copies);
   fabric_model u_fabric_model (.aclk, .rx_frame, .rx_port, .tx_frame,
      .tx_port, .mirror_rx, .mirror_tx);

   // ****************************************************************
   // Bus tasks and checks
   // ****************************************************************
   // A write offers address and data together, waits for the response
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("bresp", s_axi_bresp, er)
   endtask : wr

   // A read holds rready until the data beat is seen
   task automatic rd(input logic [9:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK("rdata", s_axi_rdata, e)
      `CHK("rresp", s_axi_rresp, er)
   endtask : rd

   // Copies counted since the last check; sampled mid-cycle to avoid races
   task automatic hits(input int er, input int et);
      repeat (3) @(negedge aclk);
      `CHK("rx copies", u_fabric_model.rx_hits - rx_base, er)
      `CHK("tx copies", u_fabric_model.tx_hits - tx_base, et)
      rx_base = u_fabric_model.rx_hits;
      tx_base = u_fabric_model.tx_hits;
   endtask : hits

   task automatic stop_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // ****************************************************************
   // Clock, watchdog and test sequence
   // ****************************************************************
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Whole sequence needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      stop_test();
   end

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then writable and read-only bits of each register
      for (int i = 0; i < 4; i++)
      begin
         rd(addr[i], 32'h0, OK);
         wr(addr[i], 32'hFFFF_FFFF, 4'hF, OK);
         rd(addr[i], wmask[i], OK);
         wr(addr[i], 32'h0, 4'hF, OK);
      end
      wr(A_ING, 32'hFFFF_FFFF, 4'h2, OK);
      rd(A_ING, 32'h0000_FF00, OK);
      wr(10'h3FC, 32'hFFFF_FFFF, 4'hF, ERR);
      rd(10'h3FC, 32'h0, ERR);
      // Global enable off: nothing mirrored, block option has no effect until enable is set
      wr(A_ING, 32'h0001_FFFF, 4'hF, OK);
      wr(A_EGR, 32'h0001_FFFF, 4'hF, OK);
      wr(A_CAP, 32'h0000_4007, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b1, 5'h03, 4);
      hits(0, 0);
      `CHK("port sel", capture_port_select, 5'h07)
      `CHK("only copies", capture_only_copies, 1'b0)
      wr(A_CAP, 32'h0000_C007, 4'hF, OK);
      hits(0, 0);
      `CHK("only copies", capture_only_copies, 1'b1)
      wr(A_CAP, 32'h0000_8011, 4'hF, OK);
      hits(0, 0);
      `CHK("port sel", capture_port_select, 5'h11)
      `CHK("only copies", capture_only_copies, 1'b0)
      // Per-port mask mapping in both directions, ports above 16 never
      wr(A_ING, {15'h0, IN_M}, 4'hF, OK);
      wr(A_EGR, {15'h0, EG_M}, 4'hF, OK);
      for (int p = 0; p < 32; p++)
      begin
         u_fabric_model.burst(1'b1, 1'b1, p[4:0], 1);
         hits(p < 17 ? int'(IN_M[p]) : 0,
              p < 17 ? int'(EG_M[p]) : 0);
      end
      // Thinning one in three; unmasked frames do not advance the count
      wr(A_ING, 32'h2000_0004, 4'hF, OK);
      wr(A_DIV, 32'h0000_0003, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 4);
      u_fabric_model.burst(1'b1, 1'b0, 5'h05, 4);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 5);
      hits(3, 0);
      // Rewriting the divider restarts the count
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 2);
      wr(A_DIV, 32'h0000_0003, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 1);
      hits(0, 0);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 2);
      hits(1, 0);
      // Divider of one or zero, and thinning off, pass every frame
      wr(A_DIV, 32'h0000_0001, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 4);
      hits(4, 0);
      wr(A_DIV, 32'h0000_0000, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 4);
      hits(4, 0);
      wr(A_DIV, 32'h0000_0003, 4'hF, OK);
      wr(A_ING, 32'h0000_0004, 4'hF, OK);
      u_fabric_model.burst(1'b1, 1'b0, 5'h02, 4);
      hits(4, 0);
      stop_test();
   end
endmodule : tb_port_mirror_selector
`default_nettype wire
